/* File: lsp_map.svh */
// Timing counts, reset values and bit positions for the LED and strap pin control
`ifndef LSP_MAP_SVH
`define LSP_MAP_SVH

// Clock rate in kHz for cycle counts
`define LSP_CLK_KHZ 100000
// Cycles the sampled straps settle after reset before they are final
`define LSP_CAPTURE_CYCLES 4'h8
// Half period of the activity blink, in milliseconds
`define LSP_BLINK_HALF_MS 40
// Strap defaults until the first capture: regulator on, interrupt function
`define LSP_REG_DISABLE_RST 1'b0
`define LSP_FUNC_SEL_RST 1'b1
// Positions in the synchroniser vector
`define LSP_SYNC_EXT_RESET 0
`define LSP_SYNC_ACT_LED 1
`define LSP_SYNC_SPEED_LED 2
`define LSP_SYNC_SHARED 3
`define LSP_SYNC_MDIO 4
`define LSP_SYNC_MDC 5
`define LSP_SYNC_WIDTH 6

`endif

/* File: lsp_pkg.sv */
// Types for the LED and strap pin control
`default_nettype none
package lsp_pkg;

    typedef enum logic {
        LSP_ST_CAPTURE,
        LSP_ST_RUN
    } lsp_state_t;

    typedef struct packed {
        logic regulator_disable_strap;
        logic pin_function_select_strap;
    } lsp_straps_t;

    typedef struct packed {
        logic link_up;
        logic activity;
        logic speed_100;
        logic isolate;
    } lsp_line_status_t;

endpackage
`default_nettype wire

/* File: lsp_pin_control.sv */
// LED indicators, strap capture and shared pin function select
`timescale 1ns/1ps
`default_nettype none
`include "lsp_map.svh"

module lsp_pin_control
    import lsp_pkg::*;
#(
    parameter int BLINK_HALF_CYCLES = `LSP_BLINK_HALF_MS * (`LSP_CLK_KHZ)
) (
    // Clock and power-on reset
    input wire logic clk_i,
    input wire logic rst_i,
    // External system reset pin
    input wire logic external_reset_n_i,
    // Line status from the transceiver core
    input wire lsp_line_status_t line_status_i,
    input wire logic interrupt_request_i,
    input wire logic symbol_mode_i,
    // Link activity indicator pin, shared with regulator disable strap
    input wire logic link_activity_indicator_i,
    output logic link_activity_indicator_o,
    output logic link_activity_indicator_oe_o,
    // Speed indicator pin, shared with pin function select strap
    input wire logic speed_indicator_i,
    output logic speed_indicator_o,
    output logic speed_indicator_oe_o,
    // Shared interrupt / transmit error / symbol bit 4 pin
    input wire logic shared_pin_i,
    output logic shared_pin_o,
    output logic shared_pin_oe_o,
    output logic transmit_error_input_o,
    output logic transmit_symbol_bit4_o,
    // Management pins and their core side
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    input wire logic mdc_i,
    input wire logic mgmt_data_out_i,
    input wire logic mgmt_drive_i,
    output logic mgmt_data_in_o,
    output logic mgmt_clock_o,
    // Configuration and reset status
    output lsp_straps_t straps_o,
    output logic core_regulator_enable_o,
    output logic core_reset_o
);

    localparam int BLINK_W = $clog2(BLINK_HALF_CYCLES + 1);

    // ==========================================================
    // Pin synchronisers
    logic [`LSP_SYNC_WIDTH-1:0] pins_async;
    logic [`LSP_SYNC_WIDTH-1:0] sync1_reg;
    logic [`LSP_SYNC_WIDTH-1:0] sync2_reg;

    assign pins_async = {mdc_i, mdio_i, shared_pin_i, speed_indicator_i,
                         link_activity_indicator_i, external_reset_n_i};

    genvar gi;
    generate
        for (gi = 0; gi < `LSP_SYNC_WIDTH; gi++) begin : g_sync
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pins_async[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    logic ext_reset_n_s;
    assign ext_reset_n_s = sync2_reg[`LSP_SYNC_EXT_RESET];

    // ==========================================================
    // Strap capture sequence
    lsp_state_t state_reg, state_next;
    logic [3:0] cap_cnt_reg, cap_cnt_next;
    lsp_straps_t straps_reg, straps_next;

    always_comb begin
        state_next = state_reg;
        cap_cnt_next = cap_cnt_reg;
        straps_next = straps_reg;
        unique case (state_reg)
            LSP_ST_CAPTURE: begin
                // Pins are released here, so sampled levels are the strap resistors
                straps_next.regulator_disable_strap = sync2_reg[`LSP_SYNC_ACT_LED];
                straps_next.pin_function_select_strap = sync2_reg[`LSP_SYNC_SPEED_LED];
                if (!ext_reset_n_s) begin
                    cap_cnt_next = 4'h0;
                end else if (cap_cnt_reg == `LSP_CAPTURE_CYCLES - 4'h1) begin
                    state_next = LSP_ST_RUN;
                end else begin
                    cap_cnt_next = cap_cnt_reg + 4'h1;
                end
            end
            LSP_ST_RUN: begin
                if (!ext_reset_n_s) begin
                    state_next = LSP_ST_CAPTURE;
                    cap_cnt_next = 4'h0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= LSP_ST_CAPTURE;
            cap_cnt_reg <= 4'h0;
            straps_reg <= '{`LSP_REG_DISABLE_RST, `LSP_FUNC_SEL_RST};
        end else begin
            state_reg <= state_next;
            cap_cnt_reg <= cap_cnt_next;
            straps_reg <= straps_next;
        end
    end

    logic run;
    assign run = (state_reg == LSP_ST_RUN);

    // ==========================================================
    // Blink divider and activity stretch
    logic [BLINK_W-1:0] blink_cnt_reg, blink_cnt_next;
    logic blink_tick;
    logic blink_phase_reg, blink_phase_next;
    logic act_seen_reg, act_seen_next;

    assign blink_tick = (blink_cnt_reg == BLINK_W'(BLINK_HALF_CYCLES - 1));

    always_comb begin
        blink_cnt_next = blink_tick ? '0 : blink_cnt_reg + BLINK_W'(1);
        blink_phase_next = blink_phase_reg;
        act_seen_next = act_seen_reg;
        // A whole dark half period per burst keeps even short frames visible
        if (blink_tick) begin
            if (blink_phase_reg && act_seen_reg) begin
                blink_phase_next = 1'b0;
                act_seen_next = 1'b0;
            end else if (!blink_phase_reg) begin
                blink_phase_next = 1'b1;
            end
        end
        // New activity wins over the consume above
        if (line_status_i.activity) begin
            act_seen_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            blink_cnt_reg <= '0;
            blink_phase_reg <= 1'b1;
            act_seen_reg <= 1'b0;
        end else begin
            blink_cnt_reg <= blink_cnt_next;
            blink_phase_reg <= blink_phase_next;
            act_seen_reg <= act_seen_next;
        end
    end

    // ==========================================================
    // Indicators and shared pin
    logic act_led_reg, act_led_next;
    logic speed_led_reg, speed_led_next;
    logic shared_reg, shared_next;
    logic tx_error_reg, tx_error_next;
    logic tx_bit4_reg, tx_bit4_next;
    logic mdio_reg, mdio_next;
    logic shared_s;

    assign shared_s = sync2_reg[`LSP_SYNC_SHARED];

    always_comb begin
        act_led_next = run && line_status_i.link_up && blink_phase_reg;
        speed_led_next = run && line_status_i.speed_100 && !line_status_i.isolate;
        shared_next = !(run && interrupt_request_i);
        tx_error_next = 1'b0;
        tx_bit4_next = 1'b0;
        if (run && !straps_reg.pin_function_select_strap) begin
            if (symbol_mode_i) begin
                tx_bit4_next = shared_s;
            end else begin
                tx_error_next = shared_s;
            end
        end
        mdio_next = mgmt_data_out_i;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            act_led_reg <= 1'b0;
            speed_led_reg <= 1'b0;
            shared_reg <= 1'b1;
            tx_error_reg <= 1'b0;
            tx_bit4_reg <= 1'b0;
            mdio_reg <= 1'b0;
        end else begin
            act_led_reg <= act_led_next;
            speed_led_reg <= speed_led_next;
            shared_reg <= shared_next;
            tx_error_reg <= tx_error_next;
            tx_bit4_reg <= tx_bit4_next;
            mdio_reg <= mdio_next;
        end
    end

    // Strap pins stay undriven during capture so the resistors set the level
    assign link_activity_indicator_o = act_led_reg;
    assign link_activity_indicator_oe_o = run;
    assign speed_indicator_o = speed_led_reg;
    assign speed_indicator_oe_o = run;
    assign shared_pin_o = shared_reg;
    assign shared_pin_oe_o = run && straps_reg.pin_function_select_strap;
    assign transmit_error_input_o = tx_error_reg;
    assign transmit_symbol_bit4_o = tx_bit4_reg;
    assign mdio_o = mdio_reg;
    assign mdio_oe_o = run && mgmt_drive_i;
    assign mgmt_data_in_o = sync2_reg[`LSP_SYNC_MDIO];
    assign mgmt_clock_o = sync2_reg[`LSP_SYNC_MDC];
    assign straps_o = straps_reg;
    assign core_regulator_enable_o = !straps_reg.regulator_disable_strap;
    assign core_reset_o = !run;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_strap_held: assert property (run && $past(run) |-> $stable(straps_reg))
        else $error("straps changed outside capture");
    a_strap_sample: assert property (!run |=> straps_reg.regulator_disable_strap
            == $past(sync2_reg[`LSP_SYNC_ACT_LED]))
        else $error("regulator strap not sampled in capture");
    a_led_steady: assert property (run && line_status_i.link_up && blink_phase_reg
            |=> link_activity_indicator_o)
        else $error("link indicator off with link up");
    a_led_dark: assert property (!line_status_i.link_up |=> !link_activity_indicator_o)
        else $error("link indicator on without link");
    a_blink_toggle: assert property (blink_tick && blink_phase_reg && act_seen_reg
            |=> !blink_phase_reg ##1 (!blink_tick)[*2])
        else $error("activity blink did not start");
    a_speed_led: assert property (run && !line_status_i.isolate |=>
            speed_indicator_o == $past(line_status_i.speed_100))
        else $error("speed indicator wrong");
    a_speed_isolate: assert property (line_status_i.isolate |=> !speed_indicator_o)
        else $error("speed indicator on while isolated");
    a_shared_irq: assert property (run && straps_reg.pin_function_select_strap
            && interrupt_request_i |=> !shared_pin_o)
        else $error("interrupt not shown on shared pin");
    a_shared_input: assert property (!straps_reg.pin_function_select_strap
            |-> !shared_pin_oe_o)
        else $error("shared pin driven in input function");
    a_regulator_off: assert property (run && straps_reg.regulator_disable_strap
            |-> !core_regulator_enable_o)
        else $error("regulator left on");
    a_ext_reset: assert property (!ext_reset_n_s |=> core_reset_o ##1 core_reset_o)
        else $error("external reset not honoured");
    a_mdio_release: assert property (!mgmt_drive_i |-> !mdio_oe_o)
        else $error("management line driven without request");

    c_blink: cover property (blink_tick && blink_phase_reg && act_seen_reg && run);
    c_input_func: cover property (run && !straps_reg.pin_function_select_strap);
    c_ext_reset: cover property (run ##1 !run);

endmodule // lsp_pin_control
`default_nettype wire

/* File: lsp_board_model.sv */
// Board side of the pins: strap resistors, management station and pin resolution
`timescale 1ns/1ps
`default_nettype none
module lsp_board_model (
    // Strap resistor levels and station drive
    input wire logic reg_strap_i,
    input wire logic func_strap_i,
    input wire logic host_drive_i,
    input wire logic host_data_i,
    // Device pin drivers
    input wire logic act_o_i,
    input wire logic act_oe_i,
    input wire logic speed_o_i,
    input wire logic speed_oe_i,
    input wire logic shared_o_i,
    input wire logic shared_oe_i,
    input wire logic mdio_o_i,
    input wire logic mdio_oe_i,
    // Resolved pin levels
    output logic act_pin_o,
    output logic speed_pin_o,
    output logic shared_pin_o,
    output logic mdio_pin_o
);
    // Released strap pins fall to their resistor level
    assign act_pin_o = act_oe_i ? act_o_i : reg_strap_i;
    assign speed_pin_o = speed_oe_i ? speed_o_i : func_strap_i;
    // Transmit source drives only while the device has let go
    assign shared_pin_o = shared_oe_i ? shared_o_i : host_data_i;
    // Pull-up holds the data line high when nobody drives it
    assign mdio_pin_o = mdio_oe_i ? mdio_o_i : (host_drive_i ? host_data_i : 1'b1);
endmodule // lsp_board_model
`default_nettype wire

/* File: lsp_pin_control_test.sv */
// Self-checking bench for the LED and strap pin control
`timescale 1ns/1ps
`default_nettype none
`include "lsp_map.svh"
module lsp_pin_control_test;
    import lsp_pkg::*;
    logic clk_i = 0, rst_i = 1, ext_n = 1, irq = 0, sym = 0, md_out = 0, md_drv = 0, mdc = 0;
    logic rs = 1, fs = 0, h_drv = 0, h_dat = 0, r;
    lsp_line_status_t ls = '0;
    logic l1, l1_oe, l2, l2_oe, sh, sh_oe, tx_err, tx_b4, mdo, mdo_oe, mdi, mclk, reg_en, crst;
    logic p1, p2, psh, pmd;
    lsp_straps_t straps;
    int n_errors = 0, checked = 0, exp_reg, exp_func;
    // Reference model: synchronised reset release, speed indicator, interrupt pin
    int m_cnt = 0;
    logic m_run = 0, m_spd = 0, m_irq_n = 1, m_ext_s;
    logic m_ext_q[$] = '{1'b0, 1'b0};
    always #5 clk_i = ~clk_i;
    lsp_pin_control #(.BLINK_HALF_CYCLES(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .external_reset_n_i(ext_n), .line_status_i(ls), .interrupt_request_i(irq), .symbol_mode_i(sym),
        .link_activity_indicator_i(p1), .link_activity_indicator_o(l1), .link_activity_indicator_oe_o(l1_oe),
        .speed_indicator_i(p2), .speed_indicator_o(l2), .speed_indicator_oe_o(l2_oe),
        .shared_pin_i(psh), .shared_pin_o(sh), .shared_pin_oe_o(sh_oe), .transmit_error_input_o(tx_err),
        .transmit_symbol_bit4_o(tx_b4), .mdio_i(pmd), .mdio_o(mdo), .mdio_oe_o(mdo_oe), .mdc_i(mdc),
        .mgmt_data_out_i(md_out), .mgmt_drive_i(md_drv), .mgmt_data_in_o(mdi), .mgmt_clock_o(mclk),
        .straps_o(straps), .core_regulator_enable_o(reg_en), .core_reset_o(crst));
    lsp_board_model board (.reg_strap_i(rs), .func_strap_i(fs), .host_drive_i(h_drv), .host_data_i(h_dat),
        .act_o_i(l1), .act_oe_i(l1_oe), .speed_o_i(l2), .speed_oe_i(l2_oe), .shared_o_i(sh),
        .shared_oe_i(sh_oe), .mdio_o_i(mdo), .mdio_oe_i(mdo_oe), .act_pin_o(p1), .speed_pin_o(p2),
        .shared_pin_o(psh), .mdio_pin_o(pmd));
    task automatic chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %b seen %b", nm, exp, seen);
        end
    endtask
    // Two queue slots stand for the two synchroniser stages on the reset pin
    always @(posedge clk_i) begin
        if (rst_i) begin
            m_ext_q = '{1'b0, 1'b0};
            m_cnt <= 0;
            m_run <= 1'b0;
            m_spd <= 1'b0;
            m_irq_n <= 1'b1;
        end else begin
            m_ext_q.push_back(ext_n);
            m_ext_s = m_ext_q.pop_front();
            m_spd <= m_run && ls.speed_100 && !ls.isolate;
            m_irq_n <= !(m_run && irq);
            if (!m_ext_s) begin
                m_cnt <= 0;
                m_run <= 1'b0;
            end else if (!m_run && m_cnt == `LSP_CAPTURE_CYCLES - 1) begin
                m_run <= 1'b1;
            end else if (!m_run) begin
                m_cnt <= m_cnt + 1;
            end
        end
    end
    // Outputs are settled half a period after the edge that launches them
    always @(negedge clk_i) begin
        chk("model_core_reset", crst, !m_run);
        chk("model_speed", l2, m_spd);
        chk("model_interrupt_n", sh, m_irq_n);
    end
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Bounded wait: 0 for leaving reset, 1 for the activity indicator level
    task automatic wait_for(input int which, input logic v);
        int i;
        for (i = 0; i < 40; i++) begin
            if ((which == 0 && crst === 1'b0) || (which == 1 && l1 === v)) begin
                return;
            end
            cyc(1);
        end
        $display("Error wait %0d expected %b timed out", which, v);
        n_errors++;
        end_of_test();
    endtask
    task automatic chk_straps();
        chk("straps_o", straps, {exp_reg[0], exp_func[0]});
        chk("regulator_enable", reg_en, !exp_reg[0]);
        chk("shared_oe", sh_oe, exp_func[0]);
        chk("led_oe", {l1_oe, l2_oe}, 2'b11);
    endtask
    initial begin
        void'($urandom(32'h7a9b));
        cyc(4);
        rst_i = 0;
        exp_reg = 1;
        exp_func = 0;
        wait_for(0, 1'b0);
        chk_straps();
        repeat (6) begin
            sym = $urandom;
            h_dat = $urandom;
            irq = $urandom;
            cyc(4);
            chk(sym ? "symbol_bit4" : "transmit_error", sym ? tx_b4 : tx_err, h_dat);
            chk("transmit_unused", sym ? tx_err : tx_b4, 1'b0);
            chk("shared_oe_off", sh_oe, 1'b0);
        end
        // Straps moved while running must not be taken
        rs = 0;
        fs = 1;
        cyc(12);
        chk_straps();
        $display("Test strap capture done");
        ext_n = 0;
        cyc(5);
        chk("core_reset", crst, 1'b1);
        chk("oe_released", {l1_oe, sh_oe}, 2'b00);
        ext_n = 1;
        exp_reg = 0;
        exp_func = 1;
        wait_for(0, 1'b0);
        chk_straps();
        irq = 1;
        cyc(1);
        chk("interrupt_n", sh, 1'b0);
        chk("transmit_off", {tx_err, tx_b4}, 2'b00);
        irq = 0;
        cyc(1);
        chk("interrupt_n", sh, 1'b1);
        $display("Test system reset done");
        ls.link_up = 1;
        ls.speed_100 = 1;
        cyc(2);
        chk("leds", {l1, l2}, 2'b11);
        ls.isolate = 1;
        cyc(2);
        chk("speed_isolated", l2, 1'b0);
        ls.isolate = 0;
        ls.speed_100 = 0;
        cyc(2);
        chk("speed_10", l2, 1'b0);
        ls.activity = 1;
        cyc(1);
        ls.activity = 0;
        wait_for(1, 1'b0);
        wait_for(1, 1'b1);
        cyc(30);
        chk("idle_link_on", l1, 1'b1);
        $display("Test indicators done");
        repeat (8) begin
            md_drv = 1;
            md_out = $urandom;
            cyc(1);
            chk("mdio_out", {mdo_oe, pmd}, {1'b1, md_out});
            md_drv = 0;
            h_drv = 1;
            r = $urandom;
            h_dat = r;
            mdc = $urandom;
            cyc(3);
            chk("mdio_in", {mdi, mclk}, {r, mdc});
            h_drv = 0;
        end
        $display("Test management done");
        end_of_test();
    end
endmodule // lsp_pin_control_test
`default_nettype wire
